/* verification/sacg_mcu_model.sv */
// microcontroller model clocked from the system clock, counting rising edges of the programmable clock output
`timescale 1ns/10ps
module sacg_mcu_model (
   input  wire logic clk_sys,
   input  wire logic clk_in,
   input  wire logic clr,
   output int        edges
);
   logic prev_r;
   // the output is a registered pulse stream, so edges are seen at the system rate
   always @(posedge clk_sys) begin
      if (clr) begin
         edges <= 0;
      end else if (clk_in === 1'b1 && prev_r !== 1'b1) begin
         edges <= edges + 1;
      end
      prev_r <= clk_in;
   end
endmodule

/* verification/tb_top.sv */
// self-checking bench for the suspend-aware clock output block
`timescale 1ns/10ps
module tb_top;
   localparam int POR_STB = 50;
   localparam int SUSP_D  = 40;
   localparam int WAKE_D  = 20;
   localparam int POR_ST  = 20;
   localparam int LOCK    = sacg_pkg::PLL_LOCK_CYC;
   localparam int TMO     = 30000;
   localparam logic [sacg_pkg::NUM_EP:0] ALL1 = '1;
   logic                      clk_sys;
   logic                      nrst;
   logic                      osc_input;
   logic                      osc_run;
   logic [3:0]                clock_divide_factor;
   logic                      slow_clock_disable;
   logic                      suspend_request;
   logic                      wake_request_in;
   logic                      supply_low;
   logic                      pll_tick;
   logic                      osc_output;
   logic                      osc_enable;
   logic                      pll_enable;
   logic                      pll_locked;
   logic                      clk_out;
   logic                      clock_out_stable;
   logic                      suspend_out;
   logic                      internal_reset;
   logic [sacg_pkg::NUM_EP:0] endpoint_enable;
   logic [sacg_pkg::NUM_EP:0] ecr_clr;
   logic                      cnt_clr;
   logic [7:0]                lfsr_r;
   int                        edges;
   int                        errors;
   int                        compares;
   int                        cycles;
   int                        k;
   int                        n;
   int                        f;
   int                        s;
   int                        fq[$] = '{15, 0, 1};

   sacg_top #(
      .POR_STABLE_CYCLES (POR_STB),
      .SUSP_DELAY_CYCLES (SUSP_D),
      .WAKE_DELAY_CYCLES (WAKE_D),
      .POR_START_CYCLES  (POR_ST)
   ) u_sacg_top (
      .clk_sys                  (clk_sys),
      .nrst                     (nrst),
      .osc_input                (osc_input),
      .osc_run                  (osc_run),
      .clock_divide_factor      (clock_divide_factor),
      .slow_clock_disable       (slow_clock_disable),
      .suspend_request          (suspend_request),
      .wake_request_in          (wake_request_in),
      .supply_low               (supply_low),
      .pll_tick                 (pll_tick),
      .osc_output               (osc_output),
      .osc_enable               (osc_enable),
      .pll_enable               (pll_enable),
      .pll_locked               (pll_locked),
      .programmable_clock_out   (clk_out),
      .clock_out_stable         (clock_out_stable),
      .suspend_out              (suspend_out),
      .internal_reset           (internal_reset),
      .endpoint_enable          (endpoint_enable),
      .endpoint_config_regs_clr (ecr_clr)
   );

   sacg_mcu_model u_sacg_mcu_model (
      .clk_sys (clk_sys),
      .clk_in  (clk_out),
      .clr     (cnt_clr),
      .edges   (edges)
   );

   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   // tick stream at half the system rate, so factor 0 still gives visible edges
   always @(posedge clk_sys) pll_tick <= #1 (pll_tick !== 1'b1);

   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == TMO) begin
         errors = errors + 1;
         $display("[FAIL] run length expected below %0d cycles seen %0d", TMO, cycles);
         print_verdict();
      end
   end

   function automatic logic [7:0] lfsr_next(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction

   function automatic int exp_edges(input int win, input int fac);
      return win / (2 * (fac + 1));
   endfunction

   task automatic step(input int c);
      repeat (c) @(posedge clk_sys);
      #1;
   endtask

   task automatic check_bit(input string what, input logic exp, input logic got);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic check_vec(input string what, input logic [sacg_pkg::NUM_EP:0] exp,
                            input logic [sacg_pkg::NUM_EP:0] got);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic check_range(input string what, input int lo, input int hi, input int got);
      compares++;
      if (got < lo || got > hi) begin
         errors++;
         $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask

   task automatic count_edges(input int win, output int cnt);
      cnt_clr = 1'b1;
      step(1);
      cnt_clr = 1'b0;
      step(win);
      cnt = edges;
   endtask

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial begin
      nrst = 1'b0;
      osc_input = 1'b1;
      osc_run = 1'b1;
      clock_divide_factor = 4'h3;
      slow_clock_disable = 1'b0;
      suspend_request = 1'b0;
      wake_request_in = 1'b0;
      supply_low = 1'b0;
      cnt_clr = 1'b1;
      errors = 0;
      compares = 0;
      lfsr_r = 8'h2d;
      step(2);
      check_vec("endpoint_enable", 15'h0001, endpoint_enable);
      check_vec("endpoint_config_regs_clr", ALL1, ecr_clr);
      step(1);
      nrst = 1'b1;
      count_edges(POR_ST - 3, n);
      check_range("edges before start", 0, 0, n);
      check_vec("endpoint_config_regs_clr", '0, ecr_clr);
      check_bit("clock_out_stable", 1'b0, clock_out_stable);
      for (k = POR_ST - 2; k < 3000 && clock_out_stable !== 1'b1; k++) step(1);
      check_range("stable delay", POR_ST + POR_STB - 2, 2999, k);
      $display("test power-on done");
      for (k = 0; k < 1200 && pll_locked !== 1'b1; k++) step(1);
      for (k = 0; k < 3; k++) begin
         lfsr_r = lfsr_next(lfsr_r);
         fq.push_back(int'(lfsr_r[3:0]));
      end
      while (fq.size() > 0) begin
         f = fq.pop_front();
         clock_divide_factor = f[3:0];
         step(40);
         count_edges(480, n);
         check_range("edges", exp_edges(480, f) - 2, exp_edges(480, f) + 2, n);
      end
      $display("test divider done");
      osc_input = 1'b0;
      step(4);
      check_bit("osc_output", 1'b1, osc_output);
      osc_run = 1'b0;
      step(2);
      check_bit("osc_enable", 1'b0, osc_enable);
      check_bit("pll_enable", 1'b0, pll_enable);
      check_bit("osc_output", 1'b0, osc_output);
      osc_run = 1'b1;
      step(LOCK - 100);
      check_bit("pll_locked", 1'b0, pll_locked);
      step(200);
      check_bit("pll_locked", 1'b1, pll_locked);
      osc_input = 1'b1;
      step(4);
      check_bit("osc_output", 1'b0, osc_output);
      $display("test oscillator done");
      for (s = 0; s < 2; s++) begin
         slow_clock_disable = s[0];
         // a wake pulse outside suspend must be ignored
         wake_request_in = 1'b1;
         step(2);
         wake_request_in = 1'b0;
         step(6);
         check_bit("suspend_out", 1'b0, suspend_out);
         suspend_request = 1'b1;
         step(3);
         suspend_request = 1'b0;
         for (k = 0; k < SUSP_D + 20 && suspend_out !== 1'b1; k++) step(1);
         check_range("suspend delay", SUSP_D - 2, SUSP_D + 8, k);
         check_bit("osc_enable", 1'b0, osc_enable);
         check_bit("pll_enable", 1'b0, pll_enable);
         count_edges(400, n);
         check_range("suspend edges", s ? 0 : 2, s ? 0 : 6, n);
         wake_request_in = 1'b1;
         step(2);
         wake_request_in = 1'b0;
         for (k = 0; k < WAKE_D + 20 && suspend_out !== 1'b0; k++) step(1);
         check_range("wake delay", WAKE_D - 2, WAKE_D + 8, k);
         for (k = 0; k < 1500 && pll_locked !== 1'b1; k++) step(1);
         count_edges(480, n);
         check_range("edges after wake", exp_edges(480, f) - 2, exp_edges(480, f) + 2, n);
         $display("test suspend pass %0d done", s);
      end
      // a dip well under the filter length must not reset
      supply_low = 1'b1;
      step(400);
      supply_low = 1'b0;
      step(5);
      check_bit("internal_reset", 1'b0, internal_reset);
      supply_low = 1'b1;
      step(sacg_pkg::VLOW_FILT_CYC - 10);
      check_bit("internal_reset", 1'b0, internal_reset);
      step(20);
      check_bit("internal_reset", 1'b1, internal_reset);
      check_vec("endpoint_config_regs_clr", ALL1, ecr_clr);
      check_vec("endpoint_enable", 15'h0001, endpoint_enable);
      supply_low = 1'b0;
      step(5);
      $display("test supply filter done");
      print_verdict();
   end
endmodule

/* verilog/sacg_divider.sv */
// programmable divider: one enable per (div+1) ticks of the fast clock
`timescale 1ns/10ps
module sacg_divider (
   input  wire logic       clk_sys,
   input  wire logic       nrst,
   input  wire logic       tick_en,
   input  wire logic [3:0] div,
   output logic            out_r
);
   logic [3:0] cnt_r;
   logic [3:0] cnt_nxt;
   logic       out_nxt;
   always_comb begin
      cnt_nxt = cnt_r;
      // one-cycle pulse; holding the level would freeze the output at factor 0
      out_nxt = 1'b0;
      if (tick_en) begin
         if (cnt_r >= div) begin
            cnt_nxt = 4'h0;
            out_nxt = 1'b1;
         end else begin
            cnt_nxt = cnt_r + 4'h1;
            out_nxt = 1'b0;
         end
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         cnt_r <= 4'h0;
         out_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         out_r <= out_nxt;
      end
   end
endmodule

/* verilog/sacg_pkg.sv */
// constants and types shared by the suspend-aware clock output block
package sacg_pkg;
   localparam int CLK_SYS_HZ      = 10000000;
   // timing figures in their own units
   localparam int SUSP_DELAY_US   = 2000;
   localparam int WAKE_DELAY_US   = 500;
   localparam int POR_START_US    = 500;
   localparam int POR_STABLE_US   = 4000;
   localparam int VLOW_FILT_US    = 50;
   localparam int SLOW_CLK_HZ     = 100000;
   localparam int PLL_LOCK_US     = 100;
   // derived cycle counts (least times round up, longest down)
   localparam int SUSP_DELAY_CYC  = (SUSP_DELAY_US * (CLK_SYS_HZ / 1000000));
   localparam int WAKE_DELAY_CYC  = (WAKE_DELAY_US * (CLK_SYS_HZ / 1000000));
   localparam int POR_START_CYC   = (POR_START_US * (CLK_SYS_HZ / 1000000));
   localparam int POR_STABLE_CYC  = (POR_STABLE_US * (CLK_SYS_HZ / 1000000));
   localparam int VLOW_FILT_CYC   = (VLOW_FILT_US * (CLK_SYS_HZ / 1000000)) + 1;
   localparam int SLOW_HALF_CYC   = CLK_SYS_HZ / (2 * SLOW_CLK_HZ);
   localparam int PLL_LOCK_CYC    = (PLL_LOCK_US * (CLK_SYS_HZ / 1000000));
   // reset values
   localparam logic [3:0] DIV_RST = 4'h0;
   localparam int NUM_EP          = 14;
   typedef enum logic [2:0] {
      SACG_ST_POR,
      SACG_ST_RUN,
      SACG_ST_SUSP_WAIT,
      SACG_ST_SUSP,
      SACG_ST_WAKE_WAIT
   } sacg_state_t;
endpackage

/* verilog/sacg_timer.sv */
// down-counting delay timer with a done flag
`timescale 1ns/10ps
module sacg_timer #(
   parameter int WIDTH = 16
) (
   input  wire logic             clk_sys,
   input  wire logic             nrst,
   input  wire logic             load,
   input  wire logic [WIDTH-1:0] load_val,
   output logic                  done
);
   initial begin
      if (WIDTH < 2) $error("timer width too small");
   end
   logic [WIDTH-1:0] cnt_r;
   logic [WIDTH-1:0] cnt_nxt;
   always_comb begin
      cnt_nxt = cnt_r;
      if (load) begin
         cnt_nxt = load_val;
      end else if (cnt_r != '0) begin
         cnt_nxt = cnt_r - 1'b1;
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end
   assign done = (cnt_r == '0) && !load;
endmodule

/* verilog/sacg_top.sv */
// suspend-aware clock generation and output control
`timescale 1ns/10ps
module sacg_top #(
   parameter int POR_STABLE_CYCLES = sacg_pkg::POR_STABLE_CYC,
   parameter int SUSP_DELAY_CYCLES = sacg_pkg::SUSP_DELAY_CYC,
   parameter int WAKE_DELAY_CYCLES = sacg_pkg::WAKE_DELAY_CYC,
   parameter int POR_START_CYCLES  = sacg_pkg::POR_START_CYC
) (
   input  wire logic                         clk_sys,
   input  wire logic                         nrst,
   input  wire logic                         osc_input,
   input  wire logic                         osc_run,
   input  wire logic [3:0]                   clock_divide_factor,
   input  wire logic                         slow_clock_disable,
   input  wire logic                         suspend_request,
   input  wire logic                         wake_request_in,
   input  wire logic                         supply_low,
   input  wire logic                         pll_tick,
   output logic                              osc_output,
   output logic                              osc_enable,
   output logic                              pll_enable,
   output logic                              pll_locked,
   output logic                              programmable_clock_out,
   output logic                              clock_out_stable,
   output logic                              suspend_out,
   output logic                              internal_reset,
   output logic [sacg_pkg::NUM_EP:0]         endpoint_enable,
   output logic [sacg_pkg::NUM_EP:0]         endpoint_config_regs_clr
);
   localparam int TW = 16;
   initial begin
      if (POR_STABLE_CYCLES < 1 || POR_STABLE_CYCLES >= (1 << TW)) $error("bad stable count");
      if (SUSP_DELAY_CYCLES < 1 || SUSP_DELAY_CYCLES >= (1 << TW)) $error("bad suspend count");
      if (WAKE_DELAY_CYCLES < 1 || WAKE_DELAY_CYCLES >= (1 << TW)) $error("bad wake count");
      if (POR_START_CYCLES < 1 || POR_START_CYCLES >= (1 << TW)) $error("bad start count");
   end

   // supply_low, wake_request_in, osc_input and pll_tick pass two flops; first stage read only by the second
   logic [3:0] s1_r;
   logic [3:0] s2_r;
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         s1_r <= 4'h0;
         s2_r <= 4'h0;
      end else begin
         s1_r <= {supply_low, wake_request_in, osc_input, pll_tick};
         s2_r <= s1_r;
      end
   end
   logic vlow_s;
   logic wake_s;
   logic osc_s;
   logic tick_s;
   assign {vlow_s, wake_s, osc_s, tick_s} = s2_r;

   // supply-low filter: only a long dip resets
   logic [TW-1:0] vlow_cnt_r;   // a byte would wrap before the filter length
   logic [TW-1:0] vlow_cnt_nxt;
   logic          int_rst_r;
   logic          int_rst_nxt;
   always_comb begin
      vlow_cnt_nxt = '0;
      int_rst_nxt  = 1'b0;
      if (vlow_s) begin
         if (vlow_cnt_r >= TW'(sacg_pkg::VLOW_FILT_CYC)) begin
            vlow_cnt_nxt = vlow_cnt_r;
            int_rst_nxt  = 1'b1;
         end else begin
            vlow_cnt_nxt = vlow_cnt_r + 1'b1;
         end
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         vlow_cnt_r <= '0;
         int_rst_r  <= 1'b1;
      end else begin
         vlow_cnt_r <= vlow_cnt_nxt;
         int_rst_r  <= int_rst_nxt;
      end
   end
   assign internal_reset = int_rst_r;
   logic rst_any;
   assign rst_any = int_rst_r;

   // wake pulse edge, suspend request fall
   logic wake_d_r;
   logic susp_req_d_r;
   logic susp_armed_r;
   logic wake_rise;
   logic susp_fall;
   assign wake_rise = wake_s && !wake_d_r;
   assign susp_fall = susp_req_d_r && !suspend_request;

   // main sequencer
   sacg_pkg::sacg_state_t st_r;
   sacg_pkg::sacg_state_t st_nxt;
   logic                  tmr_load;
   logic [TW-1:0]         tmr_val;
   logic                  tmr_done;
   logic                  started_r;
   logic                  started_nxt;
   logic                  stable_r;
   logic                  stable_nxt;
   logic                  armed_nxt;
   logic                  stab_load;
   logic                  stab_done;
   always_comb begin
      st_nxt      = st_r;
      tmr_load    = 1'b0;
      tmr_val     = '0;
      started_nxt = started_r;
      stable_nxt  = stable_r;
      armed_nxt   = susp_armed_r;
      stab_load   = 1'b0;
      if (suspend_request) begin
         armed_nxt = 1'b1;
      end
      case (st_r)
         sacg_pkg::SACG_ST_POR: begin
            if (tmr_done) begin
               started_nxt = 1'b1;
               stab_load   = 1'b1;
               st_nxt      = sacg_pkg::SACG_ST_RUN;
            end
         end
         sacg_pkg::SACG_ST_RUN: begin
            if (stab_done && started_r) begin
               stable_nxt = 1'b1;
            end
            if (susp_fall && susp_armed_r) begin
               armed_nxt = 1'b0;
               tmr_load  = 1'b1;
               tmr_val   = TW'(SUSP_DELAY_CYCLES);
               st_nxt    = sacg_pkg::SACG_ST_SUSP_WAIT;
            end
         end
         sacg_pkg::SACG_ST_SUSP_WAIT: begin
            if (tmr_done) begin
               stable_nxt = 1'b0;
               st_nxt     = sacg_pkg::SACG_ST_SUSP;
            end
         end
         sacg_pkg::SACG_ST_SUSP: begin
            if (wake_rise) begin
               tmr_load = 1'b1;
               tmr_val  = TW'(WAKE_DELAY_CYCLES);
               st_nxt   = sacg_pkg::SACG_ST_WAKE_WAIT;
            end
         end
         sacg_pkg::SACG_ST_WAKE_WAIT: begin
            if (tmr_done) begin
               stable_nxt = 1'b1;
               st_nxt     = sacg_pkg::SACG_ST_RUN;
            end
         end
         default: begin
            st_nxt = sacg_pkg::SACG_ST_POR;
         end
      endcase
   end
   always_ff @(posedge clk_sys) begin
      if (!nrst || rst_any) begin
         st_r         <= sacg_pkg::SACG_ST_POR;
         started_r    <= 1'b0;
         stable_r     <= 1'b0;
         susp_armed_r <= 1'b0;
         wake_d_r     <= 1'b0;
         susp_req_d_r <= 1'b0;
      end else begin
         st_r         <= st_nxt;
         started_r    <= started_nxt;
         stable_r     <= stable_nxt;
         susp_armed_r <= armed_nxt;
         wake_d_r     <= wake_s;
         susp_req_d_r <= suspend_request;
      end
   end

   // timer reloads with the start delay on every reset
   logic          por_load_r;
   always_ff @(posedge clk_sys) begin
      if (!nrst || rst_any) begin
         por_load_r <= 1'b1;
      end else begin
         por_load_r <= 1'b0;
      end
   end
   sacg_timer #(.WIDTH(TW)) u_tmr (
      .clk_sys  (clk_sys),
      .nrst     (nrst),
      .load     (tmr_load || por_load_r),
      .load_val (por_load_r ? TW'(POR_START_CYCLES) : tmr_val),
      .done     (tmr_done)
   );
   sacg_timer #(.WIDTH(TW)) u_stab (
      .clk_sys  (clk_sys),
      .nrst     (nrst),
      .load     (stab_load),
      .load_val (TW'(POR_STABLE_CYCLES)),
      .done     (stab_done)
   );

   // oscillator and pll are off in suspend
   logic in_susp;
   assign in_susp    = (st_r == sacg_pkg::SACG_ST_SUSP) ||
                       (st_r == sacg_pkg::SACG_ST_WAKE_WAIT);
   assign osc_enable = osc_run && !in_susp;
   assign pll_enable = osc_enable;
   assign osc_output = osc_enable ? !osc_s : 1'b0;
   assign suspend_out = in_susp;

   // pll lock: the 48 MHz tick stream is trusted only after settling
   logic [TW-1:0] lock_cnt_r;
   logic [TW-1:0] lock_cnt_nxt;
   always_comb begin
      lock_cnt_nxt = '0;
      if (pll_enable) begin
         lock_cnt_nxt = (lock_cnt_r >= TW'(sacg_pkg::PLL_LOCK_CYC)) ? lock_cnt_r
                                                                     : lock_cnt_r + 1'b1;
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         lock_cnt_r <= '0;
      end else begin
         lock_cnt_r <= lock_cnt_nxt;
      end
   end
   assign pll_locked = (lock_cnt_r >= TW'(sacg_pkg::PLL_LOCK_CYC));

   // fast path: one enable per 48 MHz tick, divided by factor plus one
   logic fast_out;
   sacg_divider u_div (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .tick_en (tick_s && pll_locked),
      .div     (clock_divide_factor),
      .out_r   (fast_out)
   );

   // slow clock, roughly 100 kHz, from the system clock
   logic [7:0] slow_cnt_r;
   logic [7:0] slow_cnt_nxt;
   logic       slow_r;
   logic       slow_nxt;
   logic       out_r;
   logic       out_nxt;
   always_comb begin
      slow_cnt_nxt = slow_cnt_r + 8'h01;
      slow_nxt     = slow_r;
      if (slow_cnt_r >= 8'(sacg_pkg::SLOW_HALF_CYC - 1)) begin
         slow_cnt_nxt = 8'h00;
         slow_nxt     = !slow_r;
      end
      out_nxt = 1'b0;
      if (!started_r) begin
         out_nxt = 1'b0;
      end else if (in_susp || st_r == sacg_pkg::SACG_ST_SUSP_WAIT && tmr_done) begin
         out_nxt = slow_clock_disable ? 1'b0 : slow_r;
      end else begin
         out_nxt = fast_out;
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         slow_cnt_r <= 8'h00;
         slow_r     <= 1'b0;
         out_r      <= 1'b0;
      end else begin
         slow_cnt_r <= slow_cnt_nxt;
         slow_r     <= slow_nxt;
         out_r      <= out_nxt;
      end
   end
   assign programmable_clock_out = out_r;
   assign clock_out_stable       = stable_r;

   // endpoints: control endpoint (bit 0) always enabled
   logic [sacg_pkg::NUM_EP:0] ep_en_r;
   always_ff @(posedge clk_sys) begin
      if (!nrst || rst_any) begin
         ep_en_r <= '0;
      end else begin
         ep_en_r <= '0;
         ep_en_r[0] <= 1'b1;
      end
   end
   assign endpoint_enable          = ep_en_r | {{sacg_pkg::NUM_EP{1'b0}}, 1'b1};
   assign endpoint_config_regs_clr = (rst_any || !nrst) ? '1 : '0;

   AST_SUSP_DELAY: assert property (@(posedge clk_sys) disable iff (!nrst)
      $rose(st_r == sacg_pkg::SACG_ST_SUSP_WAIT) |-> !suspend_out [*8])
      else $error("suspend asserted too early");
   AST_OSC_OFF: assert property (@(posedge clk_sys) disable iff (!nrst)
      suspend_out |-> !osc_enable && !pll_enable)
      else $error("oscillator running in suspend");
   AST_OSC_RUN: assert property (@(posedge clk_sys) disable iff (!nrst)
      !osc_run |-> !osc_enable)
      else $error("oscillator on while run bit low");
   AST_EP0: assert property (@(posedge clk_sys) disable iff (!nrst)
      endpoint_enable[0] && endpoint_enable[sacg_pkg::NUM_EP:1] == '0)
      else $error("endpoint enable wrong");
   AST_VLOW_SHORT: assert property (@(posedge clk_sys) disable iff (!nrst)
      $rose(int_rst_r) |-> $past(vlow_s, 2))
      else $error("reset without supply dip");
   AST_NO_OUT_BEFORE_START: assert property (@(posedge clk_sys) disable iff (!nrst)
      !started_r |=> !programmable_clock_out)
      else $error("clock out before start");
   AST_WAKE_EXIT: assert property (@(posedge clk_sys) disable iff (!nrst || rst_any)
      (st_r == sacg_pkg::SACG_ST_SUSP) && wake_rise |=> suspend_out [*2])
      else $error("suspend dropped too soon after wake");
   AST_SLOW_CLOCK_DISABLE: assert property (@(posedge clk_sys) disable iff (!nrst)
      (st_r == sacg_pkg::SACG_ST_SUSP) && slow_clock_disable |=> !programmable_clock_out)
      else $error("slow clock running while disabled");
   AST_DIV: assert property (@(posedge clk_sys) disable iff (!nrst)
      fast_out && clock_divide_factor == 4'h1 && $stable(clock_divide_factor) |=> !fast_out)
      else $error("divider pulse spacing wrong");
   AST_DIV_PULSE: assert property (@(posedge clk_sys) disable iff (!nrst)
      fast_out |-> $past(tick_s && pll_locked))
      else $error("divider pulse without a tick");
   COV_SUSP: cover property (@(posedge clk_sys) $rose(suspend_out));
   COV_WAKE: cover property (@(posedge clk_sys) $fell(suspend_out));
   COV_STABLE: cover property (@(posedge clk_sys) $rose(clock_out_stable));
endmodule
